// ==== inc/fdc_ctl_pkg.sv ====
package fdc_ctl_pkg;
	// clock and timer scale
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	// one millisecond of the modelled 10 MHz timer base, least time rounds up
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// factor applied when the chip clock runs at 8 MHz instead of 16 MHz
	localparam int HALF_RATE_FACTOR = 2;
	localparam int TIMER_W = 8;
	localparam int UNLOAD_CODE_W = 4;
	localparam int STEP_CODE_W = 4;
	localparam int SETTLE_CODE_W = 7;
	// shift giving ms per code step: 16 ms for unload, 2 ms for settle
	localparam int UNLOAD_SHIFT = 4;
	localparam int SETTLE_SHIFT = 1;
	localparam logic [4:0] STEP_BASE_MS = 5'h10;
	localparam int NUM_DRIVES = 4;
	localparam int DRV_W = 2;
	// interrupt cause in status_reg_zero[7:5], bit 5 is the lsb
	localparam int SR_ZERO_CAUSE_LSB = 5;
	localparam logic [2:0] CAUSE_READY_CHANGE = 3'h6;
	localparam logic [2:0] CAUSE_SEEK_NORMAL = 3'h1;
	localparam logic [2:0] CAUSE_SEEK_ABNORMAL = 3'h3;
	localparam logic [7:0] SR_ZERO_INVALID = 8'h80;
	localparam logic [1:0] RATE_500K_MFM = 2'h0;
	localparam logic [3:0] READY_SYNC_RESET = 4'hf;
	typedef enum logic [2:0] {
		CMD_SENSE_INT,
		CMD_SENSE_DRIVE,
		CMD_SEEK,
		CMD_RW,
		CMD_SPECIFY,
		CMD_INVALID
	} cmd_t;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_EXEC,
		SEQ_RESULT
	} seq_state_t;
endpackage

// ==== design/ms_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module ms_timer #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clr,
	input wire logic start,
	input wire logic [W-1:0] ms_count,
	input wire logic ms_tick,
	output logic done,
	output logic busy
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic busy_r;
	logic busy_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (clr) begin
			busy_nxt = 1'b0;
			cnt_nxt = '0;
		end else if (start) begin
			busy_nxt = 1'b1;
			cnt_nxt = ms_count;
		end else if (busy_r && ms_tick) begin
			// a count of zero or one expires on the next millisecond tick
			if (cnt_r <= W'(1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				cnt_nxt = '0;
			end else begin
				cnt_nxt = cnt_r - W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign busy = busy_r;
endmodule
`default_nettype wire

// ==== design/fdc_interrupt_timer_reset_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdc_interrupt_timer_reset_control #(
	parameter int MS_CYCLES = fdc_ctl_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hw_reset_pin,
	input wire logic power_good_pin,
	input wire logic clock_stable_pin,
	input wire logic [3:0] drive_ready_pin,
	input wire logic soft_reset_write,
	input wire logic soft_reset_value,
	input wire logic rate_write,
	input wire logic [1:0] rate_value,
	input wire logic half_rate_clock,
	input wire logic cmd_valid,
	input wire fdc_ctl_pkg::cmd_t cmd_op,
	input wire logic [1:0] cmd_drive,
	input wire logic [3:0] head_unload_time,
	input wire logic [3:0] step_interval_time,
	input wire logic [6:0] head_settle_time,
	input wire logic no_dma_select,
	input wire logic [7:0] drive_status_in,
	input wire logic exec_data_req,
	input wire logic result_enter,
	input wire logic result_done,
	input wire logic host_data_access,
	input wire logic seek_done,
	input wire logic seek_abnormal,
	input wire logic [1:0] seek_drive,
	input wire logic stepping_active,
	input wire logic head_load_rise,
	output logic irq,
	output logic cmd_accept,
	output logic cmd_refused,
	output logic exec_phase_flag,
	output logic transfer_direction_flag,
	output logic host_request_flag,
	output logic [3:0] drive_seeking_flags,
	output logic [7:0] result_byte,
	output logic [7:0] status_reg_zero,
	output logic non_dma_mode,
	output logic [1:0] data_rate,
	output logic soft_reset_active,
	output logic seq_reset,
	output logic high_current_driver_en,
	output logic step_pulse_due,
	output logic head_unload_due,
	output logic head_settle_done
);
	// pin synchronisers
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic [3:0] rdy_meta_r;
	logic [3:0] rdy_sync_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_r <= 4'h1;
			pin_sync_r <= 4'h1;
			rdy_meta_r <= fdc_ctl_pkg::READY_SYNC_RESET;
			rdy_sync_r <= fdc_ctl_pkg::READY_SYNC_RESET;
		end else begin
			pin_meta_r <= {1'b0, clock_stable_pin, power_good_pin, hw_reset_pin};
			pin_sync_r <= pin_meta_r;
			rdy_meta_r <= drive_ready_pin;
			rdy_sync_r <= rdy_meta_r;
		end
	end

	logic hw_rst;
	logic power_rst;
	logic seq_rst;
	assign hw_rst = pin_sync_r[0];
	assign power_rst = !pin_sync_r[1] || !pin_sync_r[2];

	// reset control and data rate
	logic soft_rst_r, soft_rst_nxt;
	logic [1:0] rate_r, rate_nxt;
	logic drv_en_r, drv_en_nxt;
	logic seq_rst_r, seq_rst_nxt;

	always_comb begin
		soft_rst_nxt = soft_rst_r;
		rate_nxt = rate_r;
		if (hw_rst || power_rst) begin
			soft_rst_nxt = 1'b1;
			rate_nxt = fdc_ctl_pkg::RATE_500K_MFM;
		end else begin
			if (soft_reset_write) begin
				soft_rst_nxt = soft_reset_value;
			end
			// rate survives soft reset
			if (rate_write) begin
				rate_nxt = rate_value;
			end
		end
		drv_en_nxt = !(hw_rst || power_rst);
		seq_rst_nxt = hw_rst || power_rst || soft_rst_nxt;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			soft_rst_r <= 1'b1;
			rate_r <= fdc_ctl_pkg::RATE_500K_MFM;
			drv_en_r <= 1'b0;
			seq_rst_r <= 1'b1;
		end else begin
			soft_rst_r <= soft_rst_nxt;
			rate_r <= rate_nxt;
			drv_en_r <= drv_en_nxt;
			seq_rst_r <= seq_rst_nxt;
		end
	end
	assign seq_rst = seq_rst_r;

	// millisecond tick
	logic [15:0] ms_cnt_r, ms_cnt_nxt;
	logic ms_tick_r, ms_tick_nxt;
	logic [15:0] ms_limit;
	assign ms_limit = half_rate_clock ? 16'(MS_CYCLES * fdc_ctl_pkg::HALF_RATE_FACTOR)
		: 16'(MS_CYCLES);

	always_comb begin
		ms_tick_nxt = 1'b0;
		ms_cnt_nxt = ms_cnt_r + 16'h0001;
		if (seq_rst || ms_cnt_r >= ms_limit - 16'h0001) begin
			ms_cnt_nxt = 16'h0000;
			ms_tick_nxt = !seq_rst;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_cnt_r <= 16'h0000;
			ms_tick_r <= 1'b0;
		end else begin
			ms_cnt_r <= ms_cnt_nxt;
			ms_tick_r <= ms_tick_nxt;
		end
	end

	// specify values
	logic [3:0] unload_code_r, step_code_r;
	logic [6:0] settle_code_r;
	logic nodma_r;
	logic [3:0] unload_code_nxt, step_code_nxt;
	logic [6:0] settle_code_nxt;
	logic nodma_nxt;

	// sequencer and interrupt state
	fdc_ctl_pkg::seq_state_t st_r, st_nxt;
	logic own_r, own_nxt;
	logic data_irq_r, data_irq_nxt;
	logic exec_r, exec_nxt;
	logic [3:0] seek_pend_r, seek_pend_nxt;
	logic [3:0] seek_bad_r, seek_bad_nxt;
	logic [3:0] rdy_pend_r, rdy_pend_nxt;
	logic [3:0] rdy_prev_r, rdy_prev_nxt;
	logic [3:0] seeking_r, seeking_nxt;
	logic [7:0] res_r, res_nxt;
	logic [7:0] sr_zero_r, sr_zero_nxt;
	logic irq_r, irq_nxt;
	logic acc_r, acc_nxt;
	logic ref_r, ref_nxt;
	logic dir_r, dir_nxt;
	logic req_r, req_nxt;
	logic [3:0] rdy_evt;
	logic [3:0] seek_evt;

	// set events per drive
	genvar gd;
	generate
		for (gd = 0; gd < fdc_ctl_pkg::NUM_DRIVES; gd++) begin : g_drv
			assign rdy_evt[gd] = rdy_sync_r[gd] != rdy_prev_r[gd];
			assign seek_evt[gd] = seek_done && seek_drive == 2'(gd);
		end
	endgenerate

	always_comb begin
		logic [2:0] cause;
		logic [1:0] drv;
		logic found;
		cause = 3'h0;
		drv = 2'h0;
		found = 1'b0;
		unload_code_nxt = unload_code_r;
		step_code_nxt = step_code_r;
		settle_code_nxt = settle_code_r;
		nodma_nxt = nodma_r;
		st_nxt = st_r;
		own_nxt = own_r;
		data_irq_nxt = data_irq_r;
		exec_nxt = exec_r;
		seek_pend_nxt = seek_pend_r;
		seek_bad_nxt = seek_bad_r;
		rdy_pend_nxt = rdy_pend_r;
		rdy_prev_nxt = rdy_sync_r;
		seeking_nxt = seeking_r;
		res_nxt = res_r;
		sr_zero_nxt = sr_zero_r;
		acc_nxt = 1'b0;
		ref_nxt = 1'b0;
		// one pending cause, seek ends first, lowest drive first
		for (int i = fdc_ctl_pkg::NUM_DRIVES - 1; i >= 0; i--) begin
			if (rdy_pend_r[i]) begin
				found = 1'b1;
				drv = 2'(i);
				cause = fdc_ctl_pkg::CAUSE_READY_CHANGE;
			end
		end
		for (int i = fdc_ctl_pkg::NUM_DRIVES - 1; i >= 0; i--) begin
			if (seek_pend_r[i]) begin
				found = 1'b1;
				drv = 2'(i);
				cause = seek_bad_r[i] ? fdc_ctl_pkg::CAUSE_SEEK_ABNORMAL
					: fdc_ctl_pkg::CAUSE_SEEK_NORMAL;
			end
		end
		// host data access clears data interrupts
		if (host_data_access) begin
			data_irq_nxt = 1'b0;
			if (st_r == fdc_ctl_pkg::SEQ_RESULT && own_r) begin
				st_nxt = fdc_ctl_pkg::SEQ_IDLE;
			end
		end
		if (st_r == fdc_ctl_pkg::SEQ_RESULT && !own_r && result_done) begin
			st_nxt = fdc_ctl_pkg::SEQ_IDLE;
		end
		if (cmd_valid) begin
			if (st_r != fdc_ctl_pkg::SEQ_IDLE ||
				(|seek_pend_r && cmd_op != fdc_ctl_pkg::CMD_SENSE_INT)) begin
				ref_nxt = 1'b1;
			end else begin
				acc_nxt = 1'b1;
				case (cmd_op)
					fdc_ctl_pkg::CMD_SENSE_INT: begin
						st_nxt = fdc_ctl_pkg::SEQ_RESULT;
						own_nxt = 1'b1;
						if (found) begin
							sr_zero_nxt = {cause, 3'h0, drv};
							if (cause == fdc_ctl_pkg::CAUSE_READY_CHANGE) begin
								rdy_pend_nxt[drv] = 1'b0;
							end else begin
								seek_pend_nxt[drv] = 1'b0;
								seeking_nxt[drv] = 1'b0;
							end
						end else begin
							sr_zero_nxt = fdc_ctl_pkg::SR_ZERO_INVALID;
						end
						res_nxt = sr_zero_nxt;
					end
					fdc_ctl_pkg::CMD_SENSE_DRIVE: begin
						st_nxt = fdc_ctl_pkg::SEQ_RESULT;
						own_nxt = 1'b1;
						res_nxt = drive_status_in;
					end
					fdc_ctl_pkg::CMD_SEEK: begin
						seeking_nxt[cmd_drive] = 1'b1;
					end
					fdc_ctl_pkg::CMD_RW: begin
						st_nxt = fdc_ctl_pkg::SEQ_EXEC;
						own_nxt = 1'b0;
						exec_nxt = nodma_r;
						data_irq_nxt = nodma_r;
					end
					fdc_ctl_pkg::CMD_SPECIFY: begin
						unload_code_nxt = head_unload_time;
						step_code_nxt = step_interval_time;
						settle_code_nxt = head_settle_time;
						nodma_nxt = no_dma_select;
					end
					default: begin
						st_nxt = fdc_ctl_pkg::SEQ_RESULT;
						own_nxt = 1'b1;
						sr_zero_nxt = fdc_ctl_pkg::SR_ZERO_INVALID;
						res_nxt = fdc_ctl_pkg::SR_ZERO_INVALID;
					end
				endcase
			end
		end
		// sets placed last so they win over a same-cycle clear
		if (st_r == fdc_ctl_pkg::SEQ_EXEC && exec_r && exec_data_req) begin
			data_irq_nxt = 1'b1;
		end
		if (st_r == fdc_ctl_pkg::SEQ_EXEC && result_enter) begin
			st_nxt = fdc_ctl_pkg::SEQ_RESULT;
			exec_nxt = 1'b0;
			data_irq_nxt = 1'b1;
		end
		for (int i = 0; i < fdc_ctl_pkg::NUM_DRIVES; i++) begin
			if (rdy_evt[i]) begin
				rdy_pend_nxt[i] = 1'b1;
			end
			if (seek_evt[i]) begin
				seek_pend_nxt[i] = 1'b1;
				seek_bad_nxt[i] = seek_abnormal;
			end
		end
		// level held until cleared
		irq_nxt = data_irq_nxt || |seek_pend_nxt || |rdy_pend_nxt;
		req_nxt = st_nxt != fdc_ctl_pkg::SEQ_EXEC || exec_nxt;
		dir_nxt = st_nxt == fdc_ctl_pkg::SEQ_RESULT;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unload_code_r <= 4'h0;
			step_code_r <= 4'h0;
			settle_code_r <= 7'h00;
			nodma_r <= 1'b0;
			st_r <= fdc_ctl_pkg::SEQ_IDLE;
			own_r <= 1'b0;
			data_irq_r <= 1'b0;
			exec_r <= 1'b0;
			seek_pend_r <= 4'h0;
			seek_bad_r <= 4'h0;
			rdy_pend_r <= 4'h0;
			rdy_prev_r <= 4'h0;
			seeking_r <= 4'h0;
			res_r <= 8'h00;
			sr_zero_r <= 8'h00;
			irq_r <= 1'b0;
			acc_r <= 1'b0;
			ref_r <= 1'b0;
			dir_r <= 1'b0;
			req_r <= 1'b0;
		end else if (seq_rst) begin
			// drives count as not ready during reset, so release flags a change
			st_r <= fdc_ctl_pkg::SEQ_IDLE;
			own_r <= 1'b0;
			data_irq_r <= 1'b0;
			exec_r <= 1'b0;
			seek_pend_r <= 4'h0;
			seek_bad_r <= 4'h0;
			rdy_pend_r <= 4'h0;
			rdy_prev_r <= 4'h0;
			seeking_r <= 4'h0;
			irq_r <= 1'b0;
			acc_r <= 1'b0;
			ref_r <= 1'b0;
			dir_r <= 1'b0;
			req_r <= 1'b0;
		end else begin
			unload_code_r <= unload_code_nxt;
			step_code_r <= step_code_nxt;
			settle_code_r <= settle_code_nxt;
			nodma_r <= nodma_nxt;
			st_r <= st_nxt;
			own_r <= own_nxt;
			data_irq_r <= data_irq_nxt;
			exec_r <= exec_nxt;
			seek_pend_r <= seek_pend_nxt;
			seek_bad_r <= seek_bad_nxt;
			rdy_pend_r <= rdy_pend_nxt;
			rdy_prev_r <= rdy_prev_nxt;
			seeking_r <= seeking_nxt;
			res_r <= res_nxt;
			sr_zero_r <= sr_zero_nxt;
			irq_r <= irq_nxt;
			acc_r <= acc_nxt;
			ref_r <= ref_nxt;
			dir_r <= dir_nxt;
			req_r <= req_nxt;
		end
	end

	// drive timers
	logic step_busy;
	logic unload_done, step_done, settle_done;
	logic [7:0] unload_ms, step_ms, settle_ms;
	assign unload_ms = {unload_code_r, 4'h0};
	assign step_ms = {3'h0, 5'(fdc_ctl_pkg::STEP_BASE_MS - {1'b0, step_code_r})};
	assign settle_ms = {settle_code_r, 1'b0};

	ms_timer #(.W(fdc_ctl_pkg::TIMER_W)) u_unload (
		.clk(clk),
		.reset_n(reset_n),
		.clr(seq_rst),
		.start(st_r == fdc_ctl_pkg::SEQ_EXEC && result_enter),
		.ms_count(unload_ms),
		.ms_tick(ms_tick_r),
		.done(unload_done),
		.busy()
	);
	ms_timer #(.W(fdc_ctl_pkg::TIMER_W)) u_step (
		.clk(clk),
		.reset_n(reset_n),
		.clr(seq_rst || !stepping_active),
		.start(stepping_active && !step_busy),
		.ms_count(step_ms),
		.ms_tick(ms_tick_r),
		.done(step_done),
		.busy(step_busy)
	);
	ms_timer #(.W(fdc_ctl_pkg::TIMER_W)) u_settle (
		.clk(clk),
		.reset_n(reset_n),
		.clr(seq_rst),
		.start(head_load_rise),
		.ms_count(settle_ms),
		.ms_tick(ms_tick_r),
		.done(settle_done),
		.busy()
	);

	logic [2:0] tdone_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tdone_r <= 3'h0;
		end else begin
			tdone_r <= {settle_done, unload_done, step_done};
		end
	end

	assign irq = irq_r;
	assign cmd_accept = acc_r;
	assign cmd_refused = ref_r;
	assign exec_phase_flag = exec_r;
	assign transfer_direction_flag = dir_r;
	assign host_request_flag = req_r;
	assign drive_seeking_flags = seeking_r;
	assign result_byte = res_r;
	assign status_reg_zero = sr_zero_r;
	assign non_dma_mode = nodma_r;
	assign data_rate = rate_r;
	assign soft_reset_active = soft_rst_r;
	assign seq_reset = seq_rst_r;
	assign high_current_driver_en = drv_en_r;
	assign step_pulse_due = tdone_r[0];
	assign head_unload_due = tdone_r[1];
	assign head_settle_done = tdone_r[2];
endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic go,
	output logic host_data_access,
	output logic irq_dma_enable
);
	// data register access launched off the falling edge, one cycle long
	always_ff @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			host_data_access <= 1'b0;
			irq_dma_enable <= 1'b0;
		end else begin
			host_data_access <= go;
			irq_dma_enable <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/fdc_ctl_checker_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdc_ctl_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cmd_accept,
	input wire fdc_ctl_pkg::cmd_t cmd_op,
	input wire logic [1:0] cmd_drive,
	input wire logic [7:0] result_byte,
	input wire logic [7:0] status_reg_zero,
	input wire logic transfer_direction_flag,
	input wire logic host_request_flag,
	input wire logic [3:0] drive_seeking_flags,
	input wire logic seek_done,
	input wire logic irq,
	input wire logic exec_phase_flag,
	input wire logic non_dma_mode,
	input wire logic result_enter,
	input wire logic hw_reset_pin,
	input wire logic power_good_pin,
	input wire logic clock_stable_pin,
	input wire logic high_current_driver_en,
	input wire logic soft_reset_active,
	input wire logic [1:0] data_rate,
	input wire logic soft_reset_write,
	input wire logic soft_reset_value,
	input wire logic seq_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_accept(fdc_ctl_pkg::cmd_t op);
		cmd_accept && $past(cmd_op) == op;
	endsequence
	sequence s_hw_reset;
		(hw_reset_pin || !power_good_pin || !clock_stable_pin) [*4];
	endsequence
	chk_invalid_result: assert property (
		s_accept(fdc_ctl_pkg::CMD_INVALID) |-> result_byte == fdc_ctl_pkg::SR_ZERO_INVALID
		&& transfer_direction_flag && host_request_flag) else $error("invalid result wrong");
	chk_seek_sets_flag: assert property (
		s_accept(fdc_ctl_pkg::CMD_SEEK) |-> ##[0:1] drive_seeking_flags[$past(cmd_drive)])
		else $error("seeking flag not set");
	chk_seek_end_irq: assert property (
		seek_done |-> ##[1:2] irq) else $error("no irq after seek end");
	chk_sense_clears_flag: assert property (
		s_accept(fdc_ctl_pkg::CMD_SENSE_INT)
		&& status_reg_zero[7:5] == fdc_ctl_pkg::CAUSE_SEEK_NORMAL
		|-> ##[0:1] !drive_seeking_flags[status_reg_zero[1:0]]) else $error("flag kept");
	chk_nondma_exec: assert property (
		s_accept(fdc_ctl_pkg::CMD_RW) && non_dma_mode |-> exec_phase_flag && irq)
		else $error("non dma execution not flagged");
	chk_result_entry: assert property (
		result_enter |=> !exec_phase_flag && irq) else $error("result entry wrong");
	chk_hw_reset_drv: assert property (
		s_hw_reset |-> !high_current_driver_en && soft_reset_active
		&& data_rate == fdc_ctl_pkg::RATE_500K_MFM) else $error("hardware reset not applied");
	chk_soft_release: assert property (
		soft_reset_write && !soft_reset_value && high_current_driver_en |=> !seq_reset)
		else $error("sequencer stays in reset");
endmodule
bind fdc_interrupt_timer_reset_control fdc_ctl_checker u_chk (.*);
`default_nettype wire

// ==== testbench/fdc_interrupt_timer_reset_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdc_interrupt_timer_reset_control_tb;
	localparam int MSC = 10;
	logic clk, reset_n, hw_reset_pin, power_good_pin, clock_stable_pin, soft_reset_value;
	logic half_rate_clock, cmd_valid, no_dma_select, seek_abnormal, stepping_active, was_acc;
	logic go, seek_done, soft_reset_write, rate_write, exec_data_req, result_enter, result_done;
	logic head_load_rise, irq_dma_enable, host_data_access, irq, cmd_accept, cmd_refused;
	logic exec_phase_flag, transfer_direction_flag, host_request_flag, non_dma_mode;
	logic soft_reset_active, seq_reset, high_current_driver_en;
	logic step_pulse_due, head_unload_due, head_settle_done;
	logic [3:0] drive_ready_pin, head_unload_time, step_interval_time, drive_seeking_flags;
	logic [1:0] rate_value, cmd_drive, seek_drive, data_rate;
	logic [6:0] head_settle_time;
	logic [7:0] drive_status_in, result_byte, status_reg_zero, pl;
	logic [4:0] ev;
	fdc_ctl_pkg::cmd_t cmd_op;
	int err_count, compares, n;
	assign {go, seek_done, soft_reset_write, rate_write, exec_data_req} = pl[7:3];
	assign {result_enter, result_done, head_load_rise} = pl[2:0];
	assign ev = {head_settle_done, head_unload_due, step_pulse_due, irq, cmd_accept | cmd_refused};
	fdc_interrupt_timer_reset_control #(.MS_CYCLES(MSC)) DUT (.*);
	host_model u_host (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic final_report();
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkrng(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic wait_ev(input int k, input int lim);
		n = 0;
		while (ev[k] !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				err_count++;
				final_report();
			end
		end
	endtask
	task automatic pulse(input int k);
		pl[k] <= 1'b1;
		@(negedge clk);
		pl[k] <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic cmd(input fdc_ctl_pkg::cmd_t op, input logic [1:0] d, input bit rd);
		cmd_op <= op;
		cmd_drive <= d;
		cmd_valid <= 1'b1;
		@(negedge clk);
		cmd_valid <= 1'b0;
		wait_ev(0, 4);
		was_acc = cmd_accept;
		@(negedge clk);
		if (rd) pulse(7);
	endtask
	initial begin
		{hw_reset_pin, half_rate_clock, cmd_valid, seek_abnormal, stepping_active} = '0;
		{power_good_pin, clock_stable_pin, no_dma_select} = 3'h7;
		{soft_reset_value, rate_value, cmd_drive, seek_drive, pl} = '0;
		cmd_op = fdc_ctl_pkg::CMD_SENSE_INT;
		drive_ready_pin = 4'hf;
		head_unload_time = 4'hf;
		step_interval_time = 4'hf;
		head_settle_time = 7'h7f;
		drive_status_in = 8'ha5;
		err_count = 0;
		compares = 0;
		reset_n = 1'b0;
		repeat (4) @(negedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk8({soft_reset_active, data_rate}, 3'h4);
		repeat (4) @(negedge clk);
		pulse(5);
		wait_ev(1, 20);
		for (int d = 0; d < 4; d++) begin
			cmd(fdc_ctl_pkg::CMD_SENSE_INT, 2'h0, 1);
			chk8(status_reg_zero, {fdc_ctl_pkg::CAUSE_READY_CHANGE, 3'h0, 2'(d)});
		end
		cmd(fdc_ctl_pkg::CMD_SENSE_INT, 2'h0, 1);
		chk8({irq, result_byte}, 9'h080);
		for (int v = 0; v < 2; v++) begin
			drive_ready_pin[2] <= v[0];
			wait_ev(1, 10);
			cmd(fdc_ctl_pkg::CMD_SENSE_INT, 2'h0, 1);
			chk8(status_reg_zero, 8'hc2);
		end
		for (int a = 0; a < 2; a++) begin
			cmd(fdc_ctl_pkg::CMD_SEEK, 2'(2 * a + 1), 0);
			chk8(drive_seeking_flags, 8'(2 << (2 * a)));
			seek_drive <= 2'(2 * a + 1);
			seek_abnormal <= a[0];
			pulse(6);
			wait_ev(1, 10);
			cmd(fdc_ctl_pkg::CMD_RW, 2'h0, 0);
			chk8(was_acc, 8'h0);
			cmd(fdc_ctl_pkg::CMD_SENSE_INT, 2'h0, 1);
			chk8(status_reg_zero, {a ? fdc_ctl_pkg::CAUSE_SEEK_ABNORMAL :
				fdc_ctl_pkg::CAUSE_SEEK_NORMAL, 3'h0, 2'(2 * a + 1)});
			chk8({irq, drive_seeking_flags}, 8'h0);
		end
		cmd(fdc_ctl_pkg::CMD_INVALID, 2'h0, 0);
		chk8({irq, transfer_direction_flag, host_request_flag, result_byte}, 11'h380);
		pulse(7);
		cmd(fdc_ctl_pkg::CMD_SENSE_DRIVE, 2'h0, 1);
		chk8(result_byte, 8'ha5);
		cmd(fdc_ctl_pkg::CMD_SPECIFY, 2'h0, 0);
		chk8(non_dma_mode, 8'h1);
		cmd(fdc_ctl_pkg::CMD_RW, 2'h0, 0);
		chk8({exec_phase_flag, irq}, 8'h3);
		pulse(7);
		chk8(irq, 8'h0);
		pulse(3);
		chk8(irq, 8'h1);
		pulse(7);
		chk8(irq, 8'h0);
		pl[2] <= 1'b1;
		@(negedge clk);
		pl[2] <= 1'b0;
		wait_ev(3, 2600);
		chkrng(n, 239 * MSC, 240 * MSC + 3);
		chk8({exec_phase_flag, irq, transfer_direction_flag}, 8'h3);
		pulse(7);
		pulse(1);
		pl[0] <= 1'b1;
		@(negedge clk);
		pl[0] <= 1'b0;
		wait_ev(4, 2600);
		chkrng(n, 253 * MSC, 254 * MSC + 3);
		no_dma_select <= 1'b0;
		cmd(fdc_ctl_pkg::CMD_SPECIFY, 2'h0, 0);
		cmd(fdc_ctl_pkg::CMD_RW, 2'h0, 0);
		chk8({exec_phase_flag, irq, host_request_flag, non_dma_mode}, 8'h0);
		pulse(2);
		chk8({exec_phase_flag, irq, transfer_direction_flag}, 8'h3);
		pulse(7);
		chk8(irq, 8'h0);
		pulse(1);
		for (int i = 0; i < 3; i++) begin
			step_interval_time <= 4'hf - 4'(i);
			half_rate_clock <= (i == 2);
			cmd(fdc_ctl_pkg::CMD_SPECIFY, 2'h0, 0);
			stepping_active <= 1'b1;
			wait_ev(2, 400);
			@(negedge clk);
			wait_ev(2, 400);
			chkrng(n + 1, (i + 1) * MSC * (i == 2 ? 2 : 1), (i + 1) * MSC * (i == 2 ? 2 : 1));
			stepping_active <= 1'b0;
		end
		half_rate_clock <= 1'b0;
		rate_value <= 2'h2;
		pulse(4);
		soft_reset_value <= 1'b1;
		pulse(5);
		chk8(seq_reset, 8'h1);
		soft_reset_value <= 1'b0;
		pulse(5);
		chk8({irq, seq_reset, data_rate}, 8'ha);
		for (int k = 0; k < 3; k++) begin
			rate_value <= 2'h3;
			pulse(4);
			hw_reset_pin <= (k == 0);
			power_good_pin <= (k != 1);
			clock_stable_pin <= (k != 2);
			repeat (5) @(negedge clk);
			chk8({high_current_driver_en, soft_reset_active, data_rate}, 8'h4);
			{hw_reset_pin, power_good_pin, clock_stable_pin} <= 3'h3;
			repeat (5) @(negedge clk);
		end
		final_report();
	end
endmodule
`default_nettype wire
